// ===== rtl/crp_ready_pulse.sv
// Conversion-ready pulse generator with reference select and register port.
`timescale 1ns/1ns
`default_nettype none
`include "crp_defs.svh"

module crp_ready_pulse (
    input  wire logic                 clk_in,              // Master clock
    input  wire logic                 rst_n_in,            // Async reset
    input  wire logic                 ce_in,               // Clock enable
    input  wire crp_pkg::crp_addr_type addr_in,            // Register address
    input  wire crp_pkg::crp_data_type wdata_in,           // Write data
    input  wire logic                 wr_in,               // Write strobe
    input  wire logic                 rd_in,               // Read strobe
    output logic [15:0]               rdata_out,           // Read data
    output logic                      conv_done_n_out,     // Ready pin level
    output logic                      conv_done_oe_out,    // Ready pin enable
    output logic                      ref_int_en_out,      // Internal ref on
    output logic                      ref_switch_out,      // Ref to pin switch
    output logic                      sample_clk_out,      // Sample clock
    output logic                      result_rate_clk_out, // Result rate clock
    output logic                      irq_out              // Interrupt level
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input crp_pkg::crp_addr_type a,
                                 input crp_pkg::crp_addr_type target);
        hit = (a == target);
    endfunction

    // Log2 of the result period in master clocks: 4 * prescale * ratio.
    function automatic crp_pkg::crp_shift_type period_log2(
        input crp_pkg::crp_pre_type pre,
        input crp_pkg::crp_osr_type decimation_ratio);
        period_log2 = 5'(`CRP_PERIOD_BASE_LOG2) + {3'h0, pre} + {2'h0, decimation_ratio};
    endfunction

    function automatic crp_pkg::crp_count_type period_len(
        input crp_pkg::crp_pre_type pre,
        input crp_pkg::crp_osr_type decimation_ratio);
        period_len = crp_pkg::crp_count_type'(18'h1) << period_log2(pre, decimation_ratio);
    endfunction

    // Half a sample period: 4 * prescale / 2 master clocks.
    function automatic crp_pkg::crp_count_type pulse_len(
        input crp_pkg::crp_pre_type pre);
        pulse_len = crp_pkg::crp_count_type'(18'h1) << ({1'b0, pre} + 3'h1);
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [`CRP_CFG_USED_MSB:0]  cfg_reg;
    logic [`CRP_EV_WIDTH-1:0]    status_reg;
    logic [`CRP_EV_WIDTH-1:0]    mask_reg;
    logic [`CRP_EV_WIDTH-1:0]    events;
    logic                        pending_reg;
    crp_pkg::crp_pre_type        act_pre_reg;
    crp_pkg::crp_osr_type        act_osr_reg;
    logic                        cfg_wr;
    logic                        ready_drive_sel;
    logic                        ext_ref_sel;

    assign cfg_wr          = wr_in && hit(addr_in, `CRP_ADDR_CFG);
    assign ready_drive_sel = cfg_reg[`CRP_CFG_DRIVE_BIT];
    assign ext_ref_sel     = cfg_reg[`CRP_CFG_EXTREF_BIT];

    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cfg_reg  <= `CRP_CFG_RESET;
            mask_reg <= `CRP_MASK_RESET;
        end else if (ce_in && wr_in) begin
            if (cfg_wr) begin
                cfg_reg <= wdata_in[`CRP_CFG_USED_MSB:0];
            end
            if (hit(addr_in, `CRP_ADDR_MASK)) begin
                mask_reg <= wdata_in[`CRP_EV_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Result period counter
    // ------------------------------------------------------------------
    crp_pkg::crp_count_type cnt_reg;
    crp_pkg::crp_count_type cnt_next;
    logic                   wrap;
    logic                   pulse_now;

    // Every period is a power of two, so the wrap compare needs no divider;
    // a ratio that is not a power of two would need a real divider here.
    // prescale codes
    assign wrap = (cnt_reg == period_len(act_pre_reg, act_osr_reg) - 18'h1);
    assign cnt_next = wrap ? '0 : cnt_reg + 18'h1;
    assign pulse_now = (cnt_reg < pulse_len(act_pre_reg));

    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cnt_reg <= '0;
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
        end
    end

    // New timing settings wait for the period boundary so that no pulse is
    // ever cut short or stretched by a configuration write.
    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            act_pre_reg <= 2'(`CRP_CFG_RESET >> `CRP_CFG_PRE_LSB);
            act_osr_reg <= 3'(`CRP_CFG_RESET >> `CRP_CFG_OSR_LSB);
            pending_reg <= 1'b0;
        end else if (ce_in) begin
            if (wrap) begin
                act_pre_reg <= cfg_reg[`CRP_CFG_PRE_MSB:`CRP_CFG_PRE_LSB];
                act_osr_reg <= cfg_reg[`CRP_CFG_OSR_MSB:`CRP_CFG_OSR_LSB];
            end
            pending_reg <= cfg_wr || (pending_reg && !wrap);
        end
    end

    // ------------------------------------------------------------------
    // Pin and clock outputs
    // ------------------------------------------------------------------
    // one low pulse per result
    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            conv_done_n_out     <= 1'b1;
            conv_done_oe_out    <= 1'b0;
            sample_clk_out      <= 1'b0;
            result_rate_clk_out <= 1'b0;
        end else if (ce_in) begin
            conv_done_n_out     <= !pulse_now;
            conv_done_oe_out    <= pulse_now || ready_drive_sel;
            sample_clk_out      <= !cnt_reg[{1'b0, act_pre_reg} + 3'h1];
            result_rate_clk_out <=
                !cnt_reg[period_log2(act_pre_reg, act_osr_reg) - 5'h1];
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ref_int_en_out <= 1'b0;
            ref_switch_out <= 1'b0;
        end else if (ce_in) begin
            ref_int_en_out <= !ext_ref_sel;
            ref_switch_out <= !ext_ref_sel;
        end
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    assign events[`CRP_EV_RESULT_BIT] = (cnt_reg == '0);
    assign events[`CRP_EV_APPLY_BIT]  = wrap && pending_reg;

    // A clear in the same cycle as a new event leaves the bit set.
    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            status_reg <= '0;
            irq_out    <= 1'b0;
        end else if (ce_in) begin
            if (wr_in && hit(addr_in, `CRP_ADDR_STATUS)) begin
                status_reg <= (status_reg & ~wdata_in[`CRP_EV_WIDTH-1:0])
                              | events;
            end else begin
                status_reg <= status_reg | events;
            end
            irq_out <= |(status_reg & mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Read data stand for one cycle and then return to zero, so a stale
    // word is never mistaken for the answer to a later read.
    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_out <= '0;
        end else if (ce_in) begin
            rdata_out <= '0;
            if (rd_in) begin
                if (hit(addr_in, `CRP_ADDR_CFG)) begin
                    rdata_out <= {9'h0, cfg_reg};
                end else if (hit(addr_in, `CRP_ADDR_STATUS)) begin
                    rdata_out <= {14'h0, status_reg};
                end else if (hit(addr_in, `CRP_ADDR_MASK)) begin
                    rdata_out <= {14'h0, mask_reg};
                end else if (hit(addr_in, `CRP_ADDR_ACTIVE)) begin
                    rdata_out <= {8'h0, pending_reg, act_osr_reg,
                                  act_pre_reg, conv_done_n_out, 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------------
    logic                   prev_n_reg;
    logic                   seen_reg;
    crp_pkg::crp_count_type low_len_reg;
    crp_pkg::crp_count_type gap_reg;
    crp_pkg::crp_count_type exp_width_reg;
    crp_pkg::crp_count_type exp_period_reg;
    logic                   fall;
    logic                   rise;

    assign fall = ce_in && prev_n_reg && !conv_done_n_out;
    assign rise = ce_in && !prev_n_reg && conv_done_n_out;

    always_ff @(posedge clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            prev_n_reg     <= 1'b1;
            seen_reg       <= 1'b0;
            low_len_reg    <= '0;
            gap_reg        <= '0;
            exp_width_reg  <= '0;
            exp_period_reg <= '0;
        end else if (ce_in) begin
            prev_n_reg  <= conv_done_n_out;
            low_len_reg <= conv_done_n_out ? '0 : low_len_reg + 18'h1;
            gap_reg     <= fall ? 18'h1 : gap_reg + 18'h1;
            if (fall) begin
                seen_reg       <= 1'b1;
                exp_width_reg  <= pulse_len(act_pre_reg);
                exp_period_reg <= period_len(act_pre_reg, act_osr_reg);
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // The clock enable is folded into the antecedents so that frozen cycles
    // never count; the release edge itself still sees reset in the sample.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_sync_reg);

    a_pulse_width_fixed: assert property (
        rise |-> low_len_reg == exp_width_reg)
        else $error("ready pulse width differs from half a sample period");

    a_width_constant: assert property (
        rise |-> low_len_reg == pulse_len(act_pre_reg))
        else $error("ready pulse width not constant");

    a_period_spacing: assert property (
        fall && seen_reg |-> gap_reg == exp_period_reg)
        else $error("ready pulses not one result period apart");

    a_one_per_result: assert property (
        ce_in && rst_sync_reg && cnt_reg == '0 |=> !conv_done_n_out [*2])
        else $error("result without a ready pulse");

    a_idle_drive: assert property (
        $past(ce_in) && conv_done_n_out && conv_done_oe_out
        |-> $past(ready_drive_sel))
        else $error("idle ready pin driven while release selected");

    a_low_is_driven: assert property (
        !conv_done_n_out |-> conv_done_oe_out)
        else $error("ready pulse not driven");

    a_ref_select: assert property (
        ce_in && rst_sync_reg ##1 1'b1
        |-> ref_int_en_out == !$past(ext_ref_sel)
            && ref_switch_out == ref_int_en_out)
        else $error("reference enable does not follow select");

    a_not_latched: assert property (
        ce_in && !conv_done_n_out && low_len_reg == exp_width_reg
            - 18'h1 && fall == 1'b0 |=> ce_in |-> conv_done_n_out)
        else $error("ready pin held low past its width");

    a_sample_clk_rate: assert property (
        ce_in && cnt_reg == '0 && act_pre_reg == 2'h0 ##1 ce_in [*3]
        |=> sample_clk_out == 1'b0)
        else $error("sample clock not a quarter of the analog clock");

    a_irq_level: assert property (
        $past(ce_in) |-> irq_out == $past(|(status_reg & mask_reg)))
        else $error("interrupt does not follow masked status");

    // A frozen clock enable must hold every piece of state, bus writes too.
    a_ce_freeze: assert property (
        !ce_in |=> $stable(cnt_reg) && $stable(conv_done_n_out)
                   && $stable(cfg_reg))
        else $error("state moved while the clock enable was low");

    a_settings_at_wrap: assert property (
        !(ce_in && wrap) |=> $stable(act_pre_reg) && $stable(act_osr_reg))
        else $error("timing settings changed inside a result period");

    a_release_idle: assert property (
        ce_in && !pulse_now && !ready_drive_sel |=> !conv_done_oe_out)
        else $error("ready pin driven between pulses while released");

    a_result_sticky: assert property (
        ce_in && rst_sync_reg && events[`CRP_EV_RESULT_BIT]
        |=> status_reg[`CRP_EV_RESULT_BIT])
        else $error("result event lost from the status register");

    c_pulse_seen: cover property (fall);
    c_full_period: cover property (fall && seen_reg);
    c_cfg_applied: cover property (events[`CRP_EV_APPLY_BIT]);
    c_irq_raised: cover property (!irq_out ##1 irq_out);
    c_frozen: cover property (!ce_in ##1 ce_in);

endmodule

`default_nettype wire

// ===== rtl/crp_defs.svh
// Constants for the conversion-ready pulse block: offsets, fields, resets.
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CRP_ADDR_CFG        4'h0
`define CRP_ADDR_STATUS     4'h1
`define CRP_ADDR_MASK       4'h2
`define CRP_ADDR_ACTIVE     4'h3

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define CRP_CFG_DRIVE_BIT   0
`define CRP_CFG_EXTREF_BIT  1
`define CRP_CFG_PRE_LSB     2
`define CRP_CFG_PRE_MSB     3
`define CRP_CFG_OSR_LSB     4
`define CRP_CFG_OSR_MSB     6
`define CRP_CFG_USED_MSB    6

// ----------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------
`define CRP_EV_RESULT_BIT   0
`define CRP_EV_APPLY_BIT    1
`define CRP_EV_WIDTH        2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CRP_CFG_RESET       7'h30
`define CRP_MASK_RESET      2'h0
`define CRP_SAMPLE_DIV      4
`define CRP_OSR_MIN_LOG2    5
`define CRP_PERIOD_BASE_LOG2 7

`endif

// ===== rtl/crp_pkg.sv
// Types shared by the conversion-ready pulse block.
package crp_pkg;
    typedef logic [3:0]  crp_addr_type;
    typedef logic [15:0] crp_data_type;
    typedef logic [17:0] crp_count_type;
    typedef logic [1:0]  crp_pre_type;
    typedef logic [2:0]  crp_osr_type;
    typedef logic [4:0]  crp_shift_type;
endpackage

// ===== verification/crp_host_irq_model.sv
// Host interrupt input model that watches the ready pin.
`timescale 1ns/1ns
`default_nettype none
module crp_host_irq_model (
    input  wire logic        clk_in,       // Master clock
    input  wire logic        rst_n_in,     // Host reset
    input  wire logic        pin_level_in, // Ready pin level
    input  wire logic        pin_oe_in,    // Ready pin enable
    output logic             pin_out,      // Resolved pin
    output logic [31:0]      pulses_out,   // Falling edges seen
    output logic [31:0]      width_out,    // Last low width
    output logic [31:0]      period_out    // Last fall to fall
);
    logic        prev_reg;
    logic [31:0] low_reg;
    logic [31:0] gap_reg;
    assign pin_out = pin_oe_in ? pin_level_in : 1'b1;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_reg   <= 1'b1;
            low_reg    <= 32'h0;
            gap_reg    <= 32'h0;
            pulses_out <= 32'h0;
            width_out  <= 32'h0;
            period_out <= 32'h0;
        end else begin
            prev_reg <= pin_out;
            gap_reg  <= gap_reg + 32'h1;
            if (!pin_out) begin
                low_reg <= low_reg + 32'h1;
            end
            if (prev_reg && !pin_out) begin
                pulses_out <= pulses_out + 32'h1;
                period_out <= gap_reg;
                gap_reg    <= 32'h1;
                low_reg    <= 32'h1;
            end
            if (!prev_reg && pin_out) begin
                width_out <= low_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the conversion-ready pulse block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                  clk_in     = 1'b0;
    logic                  rst_n_in   = 1'b0;
    logic                  ce_in      = 1'b1;
    crp_pkg::crp_addr_type addr_in    = 4'h0;
    crp_pkg::crp_data_type wdata_in   = 16'h0;
    logic                  wr_in      = 1'b0;
    logic                  rd_in      = 1'b0;
    logic [31:0]           mismatches = 0;
    logic [31:0]           num_checks = 0;
    logic [15:0]           rdata_out, rd;
    logic                  done_n, done_oe, ref_en, ref_sw, sclk, rclk;
    logic                  irq, pin;
    logic [31:0]           pulses, width, period, n, base;
    // Columns: config word, low width, pulse period.
    logic [47:0]           rows [5] = '{{16'h0001, 16'd2, 16'd128},
        {16'h0006, 16'd4, 16'd256}, {16'h0009, 16'd8, 16'd512},
        {16'h000e, 16'd16, 16'd1024}, {16'h0011, 16'd2, 16'd256}};

    always #4 clk_in = ~clk_in;

    crp_ready_pulse dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .conv_done_n_out(done_n), .conv_done_oe_out(done_oe),
        .ref_int_en_out(ref_en), .ref_switch_out(ref_sw),
        .sample_clk_out(sclk), .result_rate_clk_out(rclk),
        .irq_out(irq));
    crp_host_irq_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .pin_level_in(done_n), .pin_oe_in(done_oe), .pin_out(pin),
        .pulses_out(pulses), .width_out(width), .period_out(period));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rd = rdata_out;
    endtask
    // A missing pulse is cut short here rather than by the watchdog.
    task automatic wait_pulses(input int k);
        logic [31:0] s;
        int          t;
        s = pulses;
        t = 0;
        while (pulses < s + k && t < 6000) begin
            @(posedge clk_in);
            #1 t = t + 1;
        end
        if (t >= 6000) begin
            mismatches = mismatches + 1;
        end
    endtask
    // Counts master clocks from one rising edge of the chosen clock to the
    // next; a stuck clock is left to the watchdog.
    task automatic meas_clk(input logic use_rate);
        logic p;
        logic c;
        int   t;
        p = 1'b1;
        t = 0;
        n = 0;
        while (t < 2) begin
            @(posedge clk_in);
            #1 c = use_rate ? rclk : sclk;
            if (c && !p) begin
                t = t + 1;
            end
            if (t == 1) begin
                n = n + 1;
            end
            p = c;
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk_in);
        mismatches = mismatches + 1;
        final_report;
    end

    initial begin
        repeat (5) @(posedge clk_in);
        check(32'(done_oe), 0);
        check(32'(done_n), 1);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        bus_rd(4'h0);
        check(32'(rd), 32'h0030);
        check(32'(ref_en), 1);
        check(32'(ref_sw), 1);
        wait_pulses(2);
        check(period, 1024);
        for (int i = 0; i < 5; i++) begin
            bus_wr(4'h0, rows[i][47:32]);
            bus_rd(4'h0);
            check(32'(rd), 32'(rows[i][47:32]));
            wait_pulses(3);
            check(width, 32'(rows[i][31:16]));
            check(period, 32'(rows[i][15:0]));
            repeat (20) @(posedge clk_in);
            check(32'(done_oe), 32'(rows[i][32]));
            check(32'(pin), 1);
            check(32'(ref_en), 32'(!rows[i][33]));
            check(32'(ref_sw), 32'(!rows[i][33]));
            bus_rd(4'h3);
            check(32'(rd[6:2]), 32'(rows[i][38:34]));
            meas_clk(1'b0);
            check(n, 32'(rows[i][31:16]) << 1);
            meas_clk(1'b1);
            check(n, 32'(rows[i][15:0]));
        end
        wait_pulses(1);
        bus_rd(4'h1);
        check(32'(rd[0]), 1);
        check(32'(irq), 0);
        bus_wr(4'h2, 16'h0001);
        repeat (3) @(posedge clk_in);
        check(32'(irq), 1);
        bus_wr(4'h1, 16'h0003);
        repeat (3) @(posedge clk_in);
        check(32'(irq), 0);
        bus_rd(4'h1);
        check(32'(rd[0]), 0);
        bus_wr(4'h5, 16'hffff);
        bus_rd(4'h5);
        check(32'(rd), 0);
        wait_pulses(1);
        base = pulses;
        repeat (416) bus_rd(4'h1);
        check(pulses - base, 3);
        @(posedge clk_in);
        ce_in <= 1'b0;
        base = pulses;
        bus_wr(4'h0, 16'h0003);
        repeat (600) @(posedge clk_in);
        check(pulses - base, 0);
        ce_in <= 1'b1;
        bus_rd(4'h0);
        check(32'(rd), 32'h0011);
        bus_wr(4'h0, 16'h0003);
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        #1 check(32'(done_oe), 0);
        check(32'(ref_en), 0);
        check(32'(irq), 0);
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        bus_rd(4'h0);
        check(32'(rd), 32'h0030);
        bus_rd(4'h2);
        check(32'(rd), 0);
        wait_pulses(2);
        check(period, 1024);
        final_report;
    end
endmodule
`default_nettype wire
